// file: logic/blank_timer.sv
`timescale 1ns/1ps
module blank_timer
  import pwm_pkg::*;
#(
  parameter int CLK_NS = CLK_PERIOD_NS
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             start,
  input  wire logic [DUR_W-1:0] dur,
  output logic                  busy
);

  initial begin
    if (CLK_NS < 1) $error("clock period must be positive");
  end

  // ==========================================================
  // duration in steps to clock cycles, rounded up
  function automatic logic [BLK_W-1:0] blank_cycles(input logic [DUR_W-1:0] d);
    int ns;
    ns = int'(d) * LEB_STEP_NS;
    return BLK_W'((ns + CLK_NS - 1) / CLK_NS);
  endfunction

  blank_state_t st, nxt;

  always_comb begin
    nxt = st;
    if (start) begin
      nxt.left = blank_cycles(dur);
    end else if (st.left != '0) begin
      nxt.left = st.left - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
    end else begin
      st <= nxt;
    end
  end

  assign busy = (st.left != '0);

endmodule

// file: logic/pwm_gen.sv
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
module pwm_gen
  import pwm_pkg::*;
#(
  parameter int CLK_NS = CLK_PERIOD_NS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        fault_in,
  input  wire logic        current_limit_in,
  input  wire logic        current_reset_in,
  output logic             high_side_output,
  output logic             low_side_output
);

  initial begin
    if (CLK_NS < 1) $error("clock period must be positive");
  end

  // ==========================================================
  // helpers
  function automatic logic [CNT_W-1:0] shift_cnt(input logic [CNT_W-1:0] c,
                                                 input logic [CNT_W-1:0] p,
                                                 input logic [CNT_W-1:0] per);
    logic [CNT_W:0] s;
    s = {1'b0, c} + {1'b0, p};
    if (s > {1'b0, per}) s = s - {1'b0, per} - 1'b1;
    return s[CNT_W-1:0];
  endfunction

  function automatic logic is_compl(input mode_t m);
    return (m == M_COMP) || (m == M_VAR) || (m == M_CRST) || (m == M_COFF) || (m == M_MULTI);
  endfunction

  pwm_state_t st, nxt;
  logic             blank_busy;
  logic             blank_start;
  logic             tb_end;
  logic             act;
  logic             flt_seen;
  logic             cl_seen;
  logic             ovr;
  logic             base_h;
  logic             base_l;
  logic [CNT_W-1:0] eff;
  logic [31:0]      rd;

  blank_timer #(.CLK_NS(CLK_NS)) u_blank (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (blank_start),
    .dur     (st.blank_ctl[DUR_LSB +: DUR_W]),
    .busy    (blank_busy)
  );

  // ==========================================================
  // time base, waveform, fault handling, register file
  always_comb begin
    nxt = st;

    if (st.mode == M_MULTI || st.mode == M_VAR) begin
      eff = shift_cnt(st.cnt, st.phase, st.period);
    end else begin
      eff = st.cnt;
    end
    act = st.en && (eff <= st.duty);

    case (st.mode)
      M_INDEP: tb_end = (st.cnt >= st.phase);
      M_CRST, M_COFF: tb_end = (st.cnt >= st.period) ||
                               (current_reset_in && (st.cnt > st.duty));
      default: tb_end = (st.cnt >= st.period);
    endcase

    if (!st.en || tb_end) begin
      nxt.cnt = '0;
    end else begin
      nxt.cnt = CNT_W'(st.cnt + 1'b1);
    end

    // inputs masked while blanking runs, each only if its enable bit in blank_ctl is set
    flt_seen = fault_in && !(blank_busy && st.blank_ctl[FLT_EN_B]);
    cl_seen  = current_limit_in && (st.mode == M_CLIM) &&
               !(blank_busy && st.blank_ctl[CL_EN_B]);

    // set wins over clear
    if (flt_seen && st.en && st.fmod == FMOD_LATCH) begin
      nxt.flt_latch = 1'b1;
    end else if (st.ap_vld && st.ap_wr && st.ap_addr == A_STATUS && hwdata[ST_LATCH_B]) begin
      nxt.flt_latch = 1'b0;
    end
    if (flt_seen && st.en && st.fmod == FMOD_CYCLE) begin
      nxt.flt_cyc = 1'b1;
    end else if (tb_end || !st.en) begin
      nxt.flt_cyc = 1'b0;
    end
    if (cl_seen && st.en) begin
      nxt.cl_ovr = 1'b1;
    end else if (tb_end || !st.en) begin
      nxt.cl_ovr = 1'b0;
    end
    ovr = nxt.flt_latch || nxt.flt_cyc || nxt.cl_ovr;

    if (st.en && tb_end && st.mode == M_PP) begin
      nxt.pp_ph = ~st.pp_ph;
    end

    case (st.mode)
      M_STD, M_INDEP: begin
        base_h = act;
        base_l = 1'b0;
      end
      M_PP: begin
        base_h = act && !st.pp_ph;
        base_l = act && st.pp_ph;
      end
      M_CLIM: begin
        base_h = act;
        base_l = st.en && !act;
      end
      default: begin
        base_h = act;
        base_l = st.en && !act && is_compl(st.mode);
      end
    endcase

    if (!st.en) begin
      nxt.high = 1'b0;
      nxt.low  = 1'b0;
    end else if (ovr) begin
      nxt.high = st.fdat[1];
      nxt.low  = st.fdat[0];
    end else begin
      nxt.high = base_h;
      nxt.low  = base_l;
    end

    blank_start = (st.blank_ctl[TRIG_HR_B] && nxt.high && !st.high) ||
                  (st.blank_ctl[TRIG_HF_B] && !nxt.high && st.high) ||
                  (st.blank_ctl[TRIG_LR_B] && nxt.low && !st.low) ||
                  (st.blank_ctl[TRIG_LF_B] && !nxt.low && st.low);

    // ahb data phase write
    if (st.ap_vld && st.ap_wr) begin
      case (st.ap_addr)
        A_CTRL: begin
          nxt.en   = hwdata[CTRL_EN_B];
          nxt.mode = mode_t'(hwdata[CTRL_MODE_LSB +: 4]);
          nxt.fmod = hwdata[CTRL_FMOD_LSB +: 2];
          nxt.fdat = hwdata[CTRL_FDAT_LSB +: 2];
        end
        A_PERIOD: nxt.period = hwdata[CNT_W-1:0];
        A_DUTY:   nxt.duty = hwdata[CNT_W-1:0];
        A_PHASE:  nxt.phase = hwdata[CNT_W-1:0];
        A_BLANK:  nxt.blank_ctl = {hwdata[15:DUR_LSB], 3'h0};
        default: ;
      endcase
    end

    // ahb address phase; read data prepared for the data phase
    case (haddr[7:0])
      A_CTRL:   rd = {16'h0000, 2'h0, st.fdat, 2'h0, st.fmod, st.mode, 3'h0, st.en};
      A_PERIOD: rd = {19'h00000, st.period};
      A_DUTY:   rd = {19'h00000, st.duty};
      A_PHASE:  rd = {19'h00000, st.phase};
      A_BLANK:  rd = {16'h0000, st.blank_ctl};
      A_STATUS: rd = {3'h0, st.cnt, 11'h000, st.pp_ph, st.cl_ovr,
                      st.flt_latch, st.low, st.high};
      default:  rd = 32'h00000000;
    endcase
    nxt.ap_vld  = hsel && htrans[1] && hready;
    nxt.ap_wr   = hwrite;
    nxt.ap_addr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
    nxt.rdata   = (nxt.ap_vld && !hwrite && haddr[31:8] == 24'h000000) ? rd : 32'h00000000;
    nxt.ready   = 1'b1;
    nxt.resp    = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st           <= '0;
      st.mode      <= M_STD;
      st.fmod      <= FMOD_OFF;
      st.period    <= PERIOD_RST;
      st.duty      <= DUTY_RST;
      st.phase     <= PHASE_RST;
      st.blank_ctl <= BLANK_RST;
      st.ap_addr   <= 8'hFF;
      st.ready     <= 1'b1;
    end else begin
      st <= nxt;
    end
  end

  assign hrdata           = st.rdata;
  assign hreadyout        = st.ready;
  assign hresp            = st.resp;
  assign high_side_output = st.high;
  assign low_side_output  = st.low;

  // ==========================================================
  // assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_cl_hit;
    st.en && st.mode == M_CLIM && cl_seen;
  endsequence

  sequence s_plain(mode_t m);
    st.en && st.mode == m && st.fmod == FMOD_OFF && !st.cl_ovr && !st.flt_latch;
  endsequence

  chk_count_up: assert property (st.en && !tb_end |=> st.cnt == CNT_W'($past(st.cnt) + 1'b1))
    else $error("time base did not count up");
  chk_std_wrap: assert property (st.en && st.mode == M_STD && st.cnt == st.period |=> st.cnt == '0)
    else $error("time base did not restart at period");
  chk_active_le: assert property (s_plain(M_STD) and (st.cnt <= st.duty) |=> high_side_output)
    else $error("output not active at or below duty");
  chk_inactive_gt: assert property (s_plain(M_STD) and (st.cnt > st.duty) |=> !high_side_output)
    else $error("output active above duty");
  chk_compl_inverse: assert property (s_plain(M_COMP) |=> low_side_output == !high_side_output)
    else $error("low side not inverse of high side");
  chk_pp_alternate: assert property (st.en && st.mode == M_PP && tb_end |=> st.pp_ph != $past(st.pp_ph))
    else $error("push-pull phase did not alternate");
  chk_pp_exclusive: assert property (st.en && st.mode == M_PP |=> !(high_side_output && low_side_output))
    else $error("push-pull drove both pins");
  chk_limit_override: assert property (s_cl_hit |=> {high_side_output, low_side_output} == $past(st.fdat))
    else $error("override data not on pins");
  chk_override_hold: assert property (st.en && st.cl_ovr && !tb_end |=> st.cl_ovr)
    else $error("override released before cycle end");
  chk_indep_wrap: assert property (st.en && st.mode == M_INDEP && st.cnt == st.phase |=> st.cnt == '0)
    else $error("independent base did not wrap at phase");
  chk_reset_early: assert property (st.en && st.mode == M_CRST && current_reset_in &&
                                    st.cnt > st.duty |=> st.cnt == '0)
    else $error("current reset did not restart time base");
  chk_blank_mask: assert property (st.en && st.mode == M_CLIM && !st.cl_ovr && blank_busy &&
                                   st.blank_ctl[CL_EN_B] |=> !st.cl_ovr)
    else $error("limit input seen during blanking");

endmodule

// file: logic/pwm_pkg.sv
// Notes on behaviour
// - edge-aligned counter runs up from zero
// - output active while count at most duty
// - output inactive once count exceeds duty
// - count reaching period restarts the cycle
// - complementary mode: low is inverse high
// - push-pull alternates pulse between pins
// - push-pull drives no complementary output
// - push-pull phases share one duty value
// - multi-phase adds phase to count
// - variable phase keeps complementary low output
// - current limit truncates the active pulse
// - override drives pins from override data
// - cycle and current limit override holds until next cycle start
// - current reset restarts after inactive output
// - current reset: fixed on-time, complementary
// - constant off-time uses current reset complement
// - blanking duration counts 8 ns steps
// - independent base wraps at phase value
// - fault mode: latched, cycle, disabled
package pwm_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_PERIOD = 8'h04;
  localparam logic [7:0] A_DUTY   = 8'h08;
  localparam logic [7:0] A_PHASE  = 8'h0C;
  localparam logic [7:0] A_BLANK  = 8'h10;
  localparam logic [7:0] A_STATUS = 8'h14;

  localparam int CNT_W         = 13;
  localparam int CTRL_EN_B     = 0;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_FMOD_LSB = 8;
  localparam int CTRL_FDAT_LSB = 12;
  localparam int ST_HIGH_B     = 0;
  localparam int ST_LOW_B      = 1;
  localparam int ST_LATCH_B    = 2;
  localparam int ST_CLOVR_B    = 3;
  localparam int ST_PPPH_B     = 4;
  localparam int ST_CNT_LSB    = 16;

  // leading_edge_blanking_control layout
  localparam int TRIG_HR_B = 15;
  localparam int TRIG_HF_B = 14;
  localparam int TRIG_LR_B = 13;
  localparam int TRIG_LF_B = 12;
  localparam int FLT_EN_B  = 11;
  localparam int CL_EN_B   = 10;
  localparam int DUR_LSB   = 3;
  localparam int DUR_W     = 7;
  localparam int BLK_W     = 10;

  localparam logic [1:0] FMOD_LATCH = 2'h0;
  localparam logic [1:0] FMOD_CYCLE = 2'h1;
  localparam logic [1:0] FMOD_OFF   = 2'h3;

  localparam logic [CNT_W-1:0] PERIOD_RST = 13'h0063;
  localparam logic [CNT_W-1:0] DUTY_RST   = 13'h0000;
  localparam logic [CNT_W-1:0] PHASE_RST  = 13'h0000;
  localparam logic [15:0]      BLANK_RST  = 16'h0000;

  localparam int LEB_STEP_NS   = 8;
  localparam int CLK_PERIOD_NS = 100;

  typedef enum logic [3:0] {
    M_STD, M_COMP, M_PP, M_MULTI, M_VAR, M_CLIM, M_CRST, M_COFF, M_INDEP
  } mode_t;

  typedef struct packed {
    logic [BLK_W-1:0] left;
  } blank_state_t;

  typedef struct packed {
    logic             en;
    mode_t            mode;
    logic [1:0]       fmod;
    logic [1:0]       fdat;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] duty;
    logic [CNT_W-1:0] phase;
    logic [CNT_W-1:0] cnt;
    logic [15:0]      blank_ctl;
    logic             pp_ph;
    logic             flt_latch;
    logic             flt_cyc;
    logic             cl_ovr;
    logic             high;
    logic             low;
    logic [7:0]       ap_addr;
    logic             ap_wr;
    logic             ap_vld;
    logic [31:0]      rdata;
    logic             ready;
    logic             resp;
  } pwm_state_t;

endpackage

// file: tb/power_stage_model.sv
`timescale 1ns/1ps
// ==========================================================
// far side: fault source, current sense and inductor discharge
module power_stage_model #(
  parameter int DISCHARGE = 3
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic high_side_output,
  input  wire logic fault_cmd,
  input  wire logic cl_cmd,
  input  wire logic cr_en,
  input  wire logic slow,
  output logic      fault_in,
  output logic      current_limit_in,
  output logic      current_reset_in
);
  logic high_q;
  int   left;

  // discharge ends a while after the switch opens, then the reset pulse fires
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_in         <= 1'b0;
      current_limit_in <= 1'b0;
      current_reset_in <= 1'b0;
      high_q           <= 1'b0;
      left             <= 0;
    end else begin
      fault_in         <= fault_cmd;
      current_limit_in <= cl_cmd;
      high_q           <= high_side_output;
      current_reset_in <= 1'b0;
      if (high_q && !high_side_output) begin
        left <= slow ? 4 * DISCHARGE : DISCHARGE;
      end else if (left > 1) begin
        left <= left - 1;
      end else if (left == 1) begin
        left             <= 0;
        current_reset_in <= cr_en;
      end
    end
  end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pwm_pkg::*;
  // ==========================================================
  // signals
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        fault_cmd, cl_cmd, cr_en, slow, fault_in, current_limit_in, current_reset_in;
  logic        high_side_output, low_side_output;
  int          n_fail, checked, hc, lc, nc, nb, k;

  pwm_gen dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fault_in(fault_in), .current_limit_in(current_limit_in),
    .current_reset_in(current_reset_in), .high_side_output(high_side_output),
    .low_side_output(low_side_output));
  power_stage_model #(.DISCHARGE(3)) stage (.hclk(hclk), .hresetn(hresetn),
    .high_side_output(high_side_output), .fault_cmd(fault_cmd), .cl_cmd(cl_cmd), .cr_en(cr_en),
    .slow(slow), .fault_in(fault_in), .current_limit_in(current_limit_in),
    .current_reset_in(current_reset_in));

  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // ==========================================================
  // helpers
  task automatic summarize;
    if (n_fail == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h00000000);
    chk(r, exp);
  endtask
  function automatic logic [31:0] ctl(input logic [3:0] m, input logic [1:0] fm, input logic [1:0] fd);
    return {18'h00000, fd, 2'h0, fm, m, 4'h1};
  endfunction
  task automatic setup(input logic [31:0] per, input logic [31:0] dty, input logic [31:0] c);
    xfer(A_CTRL, 1'b1, 32'h00000300);
    xfer(A_PERIOD, 1'b1, per);
    xfer(A_DUTY, 1'b1, dty);
    xfer(A_CTRL, 1'b1, c);
    repeat (40) @(posedge hclk);
  endtask
  task automatic watch(input int n);
    hc = 0; lc = 0; nc = 0; nb = 0;
    repeat (n) begin
      @(posedge hclk);
      hc += (high_side_output === 1'b1);
      lc += (low_side_output === 1'b1);
      nc += (low_side_output === ~high_side_output);
      nb += (low_side_output === 1'b1 && high_side_output === 1'b1);
    end
  endtask
  task automatic wait_high(input logic v);
    k = 0;
    while (high_side_output !== v && k < 400) begin
      @(posedge hclk);
      k++;
    end
    if (k == 400) chk(32'h0, 32'h1);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs;
    rd(A_CTRL, 32'h00000300);
    rd(A_PERIOD, 32'h00000063);
    rd(A_DUTY, 32'h00000000);
    rd(A_PHASE, 32'h00000000);
    rd(A_BLANK, 32'h00000000);
    xfer(A_BLANK, 1'b1, 32'h0000FFFF);
    rd(A_BLANK, 32'h0000FFF8);
    xfer(8'h18, 1'b1, 32'hFFFFFFFF);
    rd(8'h18, 32'h00000000);
    xfer(A_BLANK, 1'b1, 32'h00000000);
  endtask
  task automatic t_std;
    int d[3] = '{0, 3, 9};
    foreach (d[i]) begin
      setup(32'h9, d[i], ctl(4'h0, FMOD_OFF, 2'h0));
      watch(20);
      chk(hc, 2 * (d[i] + 1));
      chk(lc, 0);
    end
    xfer(A_CTRL, 1'b1, 32'h00000300);
    xfer(A_PHASE, 1'b1, 32'h4);
    setup(32'h9, 32'h1, ctl(4'h8, FMOD_OFF, 2'h0));
    watch(20);
    chk(hc, 8);
  endtask
  task automatic t_comp;
    logic [3:0] m[3] = '{4'h1, 4'h3, 4'h4};
    int c, ph;
    xfer(A_CTRL, 1'b1, 32'h00000300);
    xfer(A_PHASE, 1'b1, 32'h2);
    foreach (m[i]) begin
      setup(32'h9, 32'h3, ctl(m[i], FMOD_OFF, 2'h0));
      watch(20);
      chk(hc, 8);
      chk(nc, 20);
      // high pin shows the count one cycle before the sampled count
      xfer(A_STATUS, 1'b0, 32'h00000000);
      c  = (int'(r[28:16]) + 9) % 10;
      ph = (m[i] == 4'h1) ? 0 : 2;
      chk(r[ST_HIGH_B], ((c + ph) % 10) <= 3);
      chk(r[ST_LOW_B], !r[ST_HIGH_B]);
    end
  endtask
  task automatic t_latch;
    setup(32'h1D, 32'h13, ctl(4'h0, FMOD_LATCH, 2'h1));
    wait_high(1'b0);
    wait_high(1'b1);
    fault_cmd <= 1'b1;
    @(posedge hclk);
    fault_cmd <= 1'b0;
    repeat (40) @(posedge hclk);
    chk({high_side_output, low_side_output}, 2'b01);
    xfer(A_STATUS, 1'b0, 32'h00000000);
    chk(r[ST_LATCH_B], 1'b1);
    xfer(A_STATUS, 1'b1, 32'h00000004);
    wait_high(1'b1);
    chk(k < 40, 1'b1);
    xfer(A_STATUS, 1'b0, 32'h00000000);
    chk(r[ST_LATCH_B], 1'b0);
  endtask
  task automatic t_pp;
    setup(32'h9, 32'h3, ctl(4'h2, FMOD_OFF, 2'h0));
    watch(20);
    chk(hc, 4);
    chk(lc, 4);
    chk(nb, 0);
  endtask
  task automatic t_cut(input logic cl, input logic [31:0] blk, input logic blanked);
    xfer(A_BLANK, 1'b1, blk);
    setup(32'h1D, 32'h13, ctl(cl ? 4'h5 : 4'h0, cl ? FMOD_OFF : FMOD_CYCLE, 2'h1));
    wait_high(1'b0);
    wait_high(1'b1);
    repeat (2) @(posedge hclk);
    if (cl) cl_cmd <= 1'b1;
    else fault_cmd <= 1'b1;
    @(posedge hclk);
    cl_cmd    <= 1'b0;
    fault_cmd <= 1'b0;
    repeat (4) @(posedge hclk);
    if (blanked) chk(high_side_output, 1'b1);
    else chk({high_side_output, low_side_output}, 2'b01);
    wait_high(1'b1);
    chk(k < 40, 1'b1);
  endtask
  task automatic t_crst;
    for (int i = 0; i < 2; i++) begin
      cr_en <= 1'b1;
      slow  <= i[0];
      setup(32'h100, 32'h4, ctl(4'h6 + i[3:0], FMOD_OFF, 2'h0));
      wait_high(1'b0);
      wait_high(1'b1);
      chk(low_side_output, 1'b0);
      wait_high(1'b0);
      chk(k, 5);
      wait_high(1'b1);
      chk(k < 30, 1'b1);
    end
    cr_en <= 1'b0;
  endtask
  // ==========================================================
  // main sequence and watchdog
  initial begin
    hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    fault_cmd = 1'b0; cl_cmd = 1'b0; cr_en = 1'b0; slow = 1'b0; hresetn = 1'b0;
    n_fail = 0; checked = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_std;
    t_comp;
    t_pp;
    t_cut(1'b0, 32'h00008BF8, 1'b1);
    t_cut(1'b0, 32'h00000BF8, 1'b0);
    t_cut(1'b1, 32'h00000000, 1'b0);
    t_cut(1'b1, 32'h000087F8, 1'b1);
    t_latch;
    t_crst;
    summarize;
  end
  initial begin
    #2000000;
    n_fail++;
    summarize;
  end
endmodule
